// file: core/uhp_pkg.sv
// What this block does
// - An overcurrent on a port drops that port's power enable.
// - In ganged mode all power enables switch together and any overcurrent cuts them all.
// - In individual mode each power enable and overcurrent input pair works on its own.
// - Bus power select and shared power select form four power configurations.
// - With the clock mode pin low the core runs from the clock multiplier loop.
// - With the clock mode pin high the 48 MHz input drives the core and the loop is powered down.
// - With the clock mode pin high the crystal oscillator cell is powered down.
// - A 6 MHz reference is multiplied to 48 MHz, which samples upstream data.
// - The hub has three ports when three port select is low, two when high.
// - Fixed port count 00, 01, 10 give removable field 00, 02, 06.
// - Fixed port count 11 gives 06 with three port select high, 0E when low.
// - Hub characteristics bit 2 is 0 for fixed count 00 and 1 for any other code.
// - Each port takes low speed slew when a low speed device is attached.
// - With the memory disable strap high the shared pin is the power select, else memory.
package uhp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_INT_STAT   = 8'h08;
  localparam logic [7:0]  ADDR_INT_MASK   = 8'h0C;
  localparam logic [7:0]  ADDR_DESC       = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          STAT_OVC_LSB    = 0;
  localparam int          STAT_PWR_LSB    = 4;
  localparam int          STAT_THREE_BIT  = 8;
  localparam int          STAT_DIRECT_BIT = 9;
  localparam int          STAT_SELF_BIT   = 10;
  localparam int          STAT_GANG_BIT   = 11;
  localparam int          INT_BUS_POWER_SELECT_BIT  = 4;
  localparam int          DESC_REMOV_LSB  = 0;
  localparam int          DESC_CMPD_BIT   = 8;
  localparam int          DESC_PORTS_LSB  = 12;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [31:0] RDATA_NONE      = 32'h0000_0000;
  localparam logic        MEM_GANG_RESET  = 1'b1;
  localparam int          REF_CLK_MHZ     = 6;
  localparam int          PLL_OUT_MHZ     = 48;
  localparam logic [3:0]  PLL_MULT        = 4'(PLL_OUT_MHZ / REF_CLK_MHZ);
  localparam logic [3:0]  PORTS_TWO       = 4'h2;
  localparam logic [3:0]  PORTS_THREE     = 4'h3;
  localparam logic [7:0]  REMOV_NONE      = 8'h00;
  localparam logic [7:0]  REMOV_P1        = 8'h02;
  localparam logic [7:0]  REMOV_P12       = 8'h06;
  localparam logic [7:0]  REMOV_P123      = 8'h0E;

  // Fixed port count strap codes
  typedef enum logic [1:0] {
    FIX_NONE = 2'b00,
    FIX_P1   = 2'b01,
    FIX_P12  = 2'b10,
    FIX_ALL  = 2'b11
  } uhp_fixed_type;

endpackage : uhp_pkg

// file: core/uhp_cfg_if.sv
`timescale 1ns/1ps
// Strap values out to the descriptor decoder, decoded fields back
interface uhp_cfg_if;
  logic       three_port_n;
  logic [1:0] fixed_count;
  logic [7:0] removable;
  logic       compound;
  logic [3:0] port_count;

  modport core   (output three_port_n, fixed_count,
                  input  removable, compound, port_count);
  modport decode (input  three_port_n, fixed_count,
                  output removable, compound, port_count);
endinterface : uhp_cfg_if

// file: core/uhp_sync.sv
`timescale 1ns/1ps
// Two stage synchroniser; first stage feeds only the second
module uhp_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } uhp_sync_state_type;

  uhp_sync_state_type r;
  uhp_sync_state_type next_r;

  // Stage shift; a reset level of all ones means no overcurrent
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.s2;

  a_sync_delay: assert property (@(posedge clk) disable iff (srst)
    ce ##1 ce |=> q == $past(d, 2))
    else $error("synchroniser delay is not two cycles");
endmodule : uhp_sync

// file: core/uhp_desc_decode.sv
`timescale 1ns/1ps
// Hub descriptor fields decoded from the port straps
module uhp_desc_decode (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  uhp_cfg_if.decode cfg
);
  typedef struct packed {
    logic [7:0] removable;
    logic       compound;
    logic [3:0] port_count;
  } uhp_desc_state_type;

  uhp_desc_state_type r;
  uhp_desc_state_type next_r;

  // Removable bitmap per strap code
  function automatic logic [7:0] remov_of(input logic [1:0] code,
                                          input logic three_n);
    case (uhp_pkg::uhp_fixed_type'(code))
      uhp_pkg::FIX_NONE: remov_of = uhp_pkg::REMOV_NONE;
      uhp_pkg::FIX_P1:   remov_of = uhp_pkg::REMOV_P1;
      uhp_pkg::FIX_P12:  remov_of = uhp_pkg::REMOV_P12;
      default:           remov_of = three_n ? uhp_pkg::REMOV_P12
                                            : uhp_pkg::REMOV_P123;
    endcase
  endfunction : remov_of

  // Decode straps into the descriptor image
  always_comb begin
    next_r            = r;
    next_r.removable  = remov_of(cfg.fixed_count, cfg.three_port_n);
    next_r.compound   = (cfg.fixed_count != uhp_pkg::FIX_NONE);
    next_r.port_count = cfg.three_port_n ? uhp_pkg::PORTS_TWO
                                         : uhp_pkg::PORTS_THREE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign cfg.removable  = r.removable;
  assign cfg.compound   = r.compound;
  assign cfg.port_count = r.port_count;

  a_desc_all_fixed: assert property (@(posedge clk) disable iff (srst)
    ce && cfg.fixed_count == 2'b11 && !cfg.three_port_n
      |=> cfg.removable == 8'h0E)
    else $error("removable field wrong for all fixed, three ports");
  a_desc_compound: assert property (@(posedge clk) disable iff (srst)
    ce |=> cfg.compound == ($past(cfg.fixed_count) != 2'b00))
    else $error("compound bit does not follow fixed count");
endmodule : uhp_desc_decode

// file: core/uhp_core.sv
`timescale 1ns/1ps
module uhp_core #(
  parameter int NP = 3
) (
  input  wire logic          CORE_CLK,
  input  wire logic          SRST,
  input  wire logic          CE,
  input  wire logic [7:0]    ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [31:0]   RDATA,
  output logic               IRQ,
  input  wire logic [NP-1:0] OVERCURRENT_N,
  output logic      [NP-1:0] PORT_POWER_ENABLE,
  input  wire logic          BUS_POWER_SELECT,
  input  wire logic          SHARED_POWER_PIN,
  input  wire logic          MEM_SHARED_POWER,
  input  wire logic          MEM_VALID,
  input  wire logic          EXT_ID_MEM_DISABLE,
  input  wire logic          CLOCK_MODE,
  output logic               CORE_CLK_DIRECT,
  output logic               PLL_POWER_DOWN,
  output logic               OSC_POWER_DOWN,
  output logic      [3:0]    PLL_MULT,
  input  wire logic          THREE_PORT_SELECT_N,
  input  wire logic [1:0]    FIXED_PORT_COUNT,
  input  wire logic [NP-1:0] LOW_SPEED_ATTACHED,
  output logic      [NP-1:0] SLEW_LOW_SPEED,
  output logic      [7:0]    DEVICE_REMOVABLE,
  output logic               HUB_CHAR_COMPOUND,
  output logic               SELF_POWERED,
  output logic               GANGED_MODE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NP-1:0] power_req;
    logic [NP-1:0] int_ovc;
    logic          int_bus;
    logic [NP-1:0] mask_ovc;
    logic          mask_bus;
    logic [NP-1:0] ovc_prev;
    logic          bus_prev;
    logic          bus_seen;
    logic [NP-1:0] pwr;
    logic [NP-1:0] slew;
    logic          mem_gang;
    logic          ganged;
    logic          self_pwr;
    logic          clk_direct;
    logic          pll_pd;
    logic          osc_pd;
    logic [3:0]    pll_mult;
    logic [7:0]    removable;
    logic          compound;
    logic [31:0]   rdata;
    logic          irq;
  } uhp_core_state_type;

  uhp_core_state_type r;
  uhp_core_state_type next_r;

  logic [NP-1:0] ovc_sync_n;
  logic [NP-1:0] ovc_now;
  logic [NP-1:0] present;
  logic [NP-1:0] ovc_rise;
  logic          ganged_now;
  logic          any_ovc;
  logic          bus_change;
  logic [31:0]   rd_word;

  uhp_cfg_if cfg ();

  // ----------------------------------------------------------------
  // Sub blocks
  // ----------------------------------------------------------------
  // Overcurrent pins are asynchronous to us in practice, so they are
  // resynchronised even though the other pins are taken as they come
  uhp_sync #(
    .W    (NP)
  ) u_ovc_sync (
    .clk  (CORE_CLK),
    .srst (SRST),
    .ce   (CE),
    .d    (OVERCURRENT_N),
    .q    (ovc_sync_n)
  );

  // Straps into the descriptor decoder
  assign cfg.three_port_n = THREE_PORT_SELECT_N;
  assign cfg.fixed_count  = FIXED_PORT_COUNT;

  uhp_desc_decode u_desc (
    .clk  (CORE_CLK),
    .srst (SRST),
    .ce   (CE),
    .cfg  (cfg)
  );

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Port power
  // ----------------------------------------------------------------
  // Ports beyond the configured count never see power
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      present[i] = (i < 2) || (cfg.port_count == uhp_pkg::PORTS_THREE);
    end
  end

  // Active overcurrent, only on existing ports
  assign ovc_now  = ~ovc_sync_n & present;
  assign any_ovc  = |ovc_now;
  assign ovc_rise = ovc_now & ~r.ovc_prev;
  // History resets low while the strap may idle high; no event until one
  // real sample is held, else every reset would fake a power change
  assign bus_change = (BUS_POWER_SELECT ^ r.bus_prev) & r.bus_seen;

  // Shared select from pin or from the latched memory value; before the
  // memory answers we stay ganged, the safer way to fail
  assign ganged_now = EXT_ID_MEM_DISABLE ? SHARED_POWER_PIN
                                         : r.mem_gang;

  // ----------------------------------------------------------------
  // Register read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = uhp_pkg::RDATA_NONE;
    if (hit(ADDR, uhp_pkg::ADDR_CTRL)) begin
      rd_word[NP-1:0] = r.power_req;
    end else if (hit(ADDR, uhp_pkg::ADDR_STATUS)) begin
      rd_word[uhp_pkg::STAT_OVC_LSB +: NP]   = ovc_now;
      rd_word[uhp_pkg::STAT_PWR_LSB +: NP]   = r.pwr;
      rd_word[uhp_pkg::STAT_THREE_BIT]       =
        (cfg.port_count == uhp_pkg::PORTS_THREE);
      rd_word[uhp_pkg::STAT_DIRECT_BIT]      = r.clk_direct;
      rd_word[uhp_pkg::STAT_SELF_BIT]        = r.self_pwr;
      rd_word[uhp_pkg::STAT_GANG_BIT]        = r.ganged;
    end else if (hit(ADDR, uhp_pkg::ADDR_INT_STAT)) begin
      rd_word[NP-1:0]                        = r.int_ovc;
      rd_word[uhp_pkg::INT_BUS_POWER_SELECT_BIT]       = r.int_bus;
    end else if (hit(ADDR, uhp_pkg::ADDR_INT_MASK)) begin
      rd_word[NP-1:0]                        = r.mask_ovc;
      rd_word[uhp_pkg::INT_BUS_POWER_SELECT_BIT]       = r.mask_bus;
    end else if (hit(ADDR, uhp_pkg::ADDR_DESC)) begin
      rd_word[uhp_pkg::DESC_REMOV_LSB +: 8]  = r.removable;
      rd_word[uhp_pkg::DESC_CMPD_BIT]        = r.compound;
      rd_word[uhp_pkg::DESC_PORTS_LSB +: 4]  = cfg.port_count;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;

    // Memory value held once it arrives
    if (MEM_VALID) begin
      next_r.mem_gang = MEM_SHARED_POWER;
    end

    // Power enables: ganged follows the port 0 request for all ports
    for (int i = 0; i < NP; i++) begin
      if (ganged_now) begin
        next_r.pwr[i] = r.power_req[0] & ~any_ovc & present[i];
      end else begin
        next_r.pwr[i] = r.power_req[i] & ~ovc_now[i] & present[i];
      end
    end

    // Four power configurations reported as two flags
    next_r.ganged   = ganged_now;
    next_r.self_pwr = ~BUS_POWER_SELECT;

    // Slew follows attached speed; absent ports stay full speed
    next_r.slew = LOW_SPEED_ATTACHED & present;

    // Clock source controls for the clock mux and analog cells
    next_r.clk_direct = CLOCK_MODE;
    next_r.pll_pd     = CLOCK_MODE;
    next_r.osc_pd     = CLOCK_MODE;
    next_r.pll_mult   = uhp_pkg::PLL_MULT;

    // Descriptor image from the decoder
    next_r.removable = cfg.removable;
    next_r.compound  = cfg.compound;

    // Edge history for events
    next_r.ovc_prev = ovc_now;
    next_r.bus_prev = BUS_POWER_SELECT;
    next_r.bus_seen = 1'b1;

    // Sticky events; read clears, a new event in that cycle survives
    if (RD && hit(ADDR, uhp_pkg::ADDR_INT_STAT)) begin
      next_r.int_ovc = '0;
      next_r.int_bus = 1'b0;
    end
    next_r.int_ovc = next_r.int_ovc | ovc_rise;
    next_r.int_bus = next_r.int_bus | bus_change;

    // Register writes; unmapped addresses are ignored
    if (WR) begin
      if (hit(ADDR, uhp_pkg::ADDR_CTRL)) begin
        next_r.power_req = WDATA[NP-1:0];
      end else if (hit(ADDR, uhp_pkg::ADDR_INT_MASK)) begin
        next_r.mask_ovc = WDATA[NP-1:0];
        next_r.mask_bus = WDATA[uhp_pkg::INT_BUS_POWER_SELECT_BIT];
      end
    end

    // Read data only in the cycle after the strobe
    next_r.rdata = RD ? rd_word : uhp_pkg::RDATA_NONE;

    // Level interrupt from the values being stored now
    next_r.irq = |(next_r.int_ovc & next_r.mask_ovc) |
                 (next_r.int_bus & next_r.mask_bus);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      r          <= '0;
      r.mem_gang <= uhp_pkg::MEM_GANG_RESET;
      r.pll_mult <= uhp_pkg::PLL_MULT;
    end else if (CE) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign RDATA             = r.rdata;
  assign IRQ               = r.irq;
  assign PORT_POWER_ENABLE = r.pwr;
  assign SLEW_LOW_SPEED    = r.slew;
  assign CORE_CLK_DIRECT   = r.clk_direct;
  assign PLL_POWER_DOWN    = r.pll_pd;
  assign OSC_POWER_DOWN    = r.osc_pd;
  assign PLL_MULT          = r.pll_mult;
  assign DEVICE_REMOVABLE  = r.removable;
  assign HUB_CHAR_COMPOUND = r.compound;
  assign SELF_POWERED      = r.self_pwr;
  assign GANGED_MODE       = r.ganged;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ovc_power_off: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE |=> (PORT_POWER_ENABLE & $past(ovc_now)) == '0)
    else $error("power stays on for a port in overcurrent");

  a_gang_together: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && ganged_now |=>
      PORT_POWER_ENABLE == '0 || PORT_POWER_ENABLE == $past(present))
    else $error("ganged power enables differ");

  a_gang_any_ovc: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && ganged_now && any_ovc |=> PORT_POWER_ENABLE == '0)
    else $error("ganged ports survive an overcurrent");

  a_indiv_ports: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && !ganged_now |=> PORT_POWER_ENABLE ==
      $past(r.power_req & ~ovc_now & present))
    else $error("individual port power wrong");

  a_power_config: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE |=> SELF_POWERED == !$past(BUS_POWER_SELECT) &&
           GANGED_MODE == $past(ganged_now))
    else $error("power configuration flags wrong");

  a_clk_from_loop: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && !CLOCK_MODE |=> !CORE_CLK_DIRECT && !PLL_POWER_DOWN)
    else $error("loop clock not selected in loop mode");

  a_clk_direct_in: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && CLOCK_MODE |=> CORE_CLK_DIRECT && PLL_POWER_DOWN)
    else $error("direct clock mode not applied");

  a_osc_powered_off: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && CLOCK_MODE |=> OSC_POWER_DOWN)
    else $error("oscillator left powered in direct mode");

  a_loop_multiply: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !CORE_CLK_DIRECT |-> PLL_MULT == 4'h8)
    else $error("loop multiplier not six to forty eight");

  a_port_count: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && THREE_PORT_SELECT_N ##1 CE && THREE_PORT_SELECT_N
      |=> PORT_POWER_ENABLE[NP-1] == 1'b0)
    else $error("third port powered in two port mode");

  a_slew_follows: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE |=> SLEW_LOW_SPEED == $past(LOW_SPEED_ATTACHED & present))
    else $error("slew does not follow attached speed");

  a_shared_pin: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && EXT_ID_MEM_DISABLE |=> GANGED_MODE == $past(SHARED_POWER_PIN))
    else $error("shared pin not used with memory disabled");

  a_event_kept: assert property (@(posedge CORE_CLK) disable iff (SRST)
    CE && ovc_rise != '0 |=> (r.int_ovc & $past(ovc_rise)) == $past(ovc_rise))
    else $error("overcurrent event lost");

endmodule : uhp_core

// file: tb/uhp_switch_model.sv
`timescale 1ns/1ps
// Behavioural model of the external port power switches
module uhp_switch_model #(
  parameter int NP = 3
) (
  input  wire logic          clk,
  input  wire logic [NP-1:0] fault,
  input  wire logic          slow,
  output logic      [NP-1:0] flag_n
);
  logic [NP-1:0] stage [0:2];

  // ----------------------------------------------------------------
  // Fault reporting
  // ----------------------------------------------------------------
  // Fault passes one flop, three when slow; flag is active low
  always_ff @(posedge clk) begin
    stage[0] <= fault;
    stage[1] <= stage[0];
    stage[2] <= stage[1];
  end
  assign flag_n = ~(slow ? stage[2] : stage[0]);
endmodule : uhp_switch_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, ce = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rv;
  logic        irq, bus_sel = 1'b1, pin_gang = 1'b0, mem_gang = 1'b0;
  logic        mem_vld = 1'b0, ext_dis = 1'b1, clk_mode = 1'b0;
  logic        three_n = 1'b0, slow = 1'b0, direct, pll_pd, osc_pd;
  logic        compound, self_pwr, ganged;
  logic [1:0]  fixed = 2'b00;
  logic [2:0]  fault = 3'b000, ls = 3'b000, oc_n, pen, slew, req;
  logic [3:0]  mult;
  logic [7:0]  remov;
  int          miscompares = 0, checks_done = 0;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  // Reference runs free: this core has no suspend output, so the
  // stop-low duty of an outside oscillator never arises here
  always #2 clk = ~clk;
  uhp_core #(.NP(3)) DUT (.CORE_CLK(clk), .SRST(srst), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .IRQ(irq), .OVERCURRENT_N(oc_n), .PORT_POWER_ENABLE(pen),
    .BUS_POWER_SELECT(bus_sel), .SHARED_POWER_PIN(pin_gang),
    .MEM_SHARED_POWER(mem_gang), .MEM_VALID(mem_vld),
    .EXT_ID_MEM_DISABLE(ext_dis), .CLOCK_MODE(clk_mode),
    .CORE_CLK_DIRECT(direct), .PLL_POWER_DOWN(pll_pd),
    .OSC_POWER_DOWN(osc_pd), .PLL_MULT(mult),
    .THREE_PORT_SELECT_N(three_n), .FIXED_PORT_COUNT(fixed),
    .LOW_SPEED_ATTACHED(ls), .SLEW_LOW_SPEED(slew),
    .DEVICE_REMOVABLE(remov), .HUB_CHAR_COMPOUND(compound),
    .SELF_POWERED(self_pwr), .GANGED_MODE(ganged));
  uhp_switch_model #(.NP(3)) SW (.clk(clk), .fault(fault), .slow(slow),
    .flag_n(oc_n));

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [2:0] present(input logic tn);
    return tn ? 3'b011 : 3'b111;
  endfunction : present
  function automatic logic [7:0] exp_remov(input logic [1:0] f,
                                           input logic tn);
    case (f)
      2'b00:   return 8'h00;
      2'b01:   return 8'h02;
      2'b10:   return 8'h06;
      default: return tn ? 8'h06 : 8'h0E;
    endcase
  endfunction : exp_remov
  // Absent third port never powers, whatever its flag says
  function automatic logic [2:0] exp_pwr(input logic [2:0] r, f,
                                         input logic g, tn);
    logic [2:0] o;
    o = f & present(tn);
    if (g) return {3{r[0] & ~|o}} & present(tn);
    return r & ~o & present(tn);
  endfunction : exp_pwr

  // ----------------------------------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------------------------------
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // Watchdog; the run needs well under 5000 cycles
  initial begin
    #(20000 * 4);
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(9));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    bus_rd(8'h00, rv); `CHK("ctrl_reset", 32'h0000_0000, rv)
    bus_rd(8'h0C, rv); `CHK("mask_reset", 32'h0000_0000, rv)
    bus_rd(8'h08, rv); `CHK("int_reset", 32'h0000_0000, rv)
    // Clock enable low: a write must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    bus_wr(8'h0C, 32'h0000_001F);
    @(posedge clk);
    ce <= 1'b1;
    bus_rd(8'h0C, rv); `CHK("ce_frozen", 32'h0000_0000, rv)
    bus_wr(8'h20, 32'hFFFF_FFFF);
    bus_rd(8'h20, rv); `CHK("unmapped", 32'h0000_0000, rv)
    // Every strap combination against the descriptor fields
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      fixed   <= i[1:0];
      three_n <= i[2];
      wait_n(4);
      `CHK("removable", exp_remov(i[1:0], i[2]), remov)
      `CHK("compound", (i[1:0] != 2'b00), compound)
      bus_rd(8'h10, rv);
      `CHK("port_count", (i[2] ? 4'h2 : 4'h3), rv[15:12])
    end
    // Clock source selection both ways
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      clk_mode <= m[0];
      wait_n(3);
      `CHK("clk_direct", m[0], direct)
      `CHK("pll_down", m[0], pll_pd)
      `CHK("osc_down", m[0], osc_pd)
      `CHK("pll_mult", 4'h8, mult)
    end
    // Four power configurations; memory gang defaults to ganged
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      bus_sel  <= c[0];
      pin_gang <= c[1];
      wait_n(3);
      `CHK("self_pwr", ~c[0], self_pwr)
      `CHK("gang_pin", c[1], ganged)
    end
    @(posedge clk);
    ext_dis <= 1'b0;
    wait_n(3);
    `CHK("gang_mem_def", 1'b1, ganged)
    @(posedge clk);
    mem_vld <= 1'b1;
    @(posedge clk);
    mem_vld <= 1'b0;
    wait_n(3);
    `CHK("gang_mem", 1'b0, ganged)
    @(posedge clk);
    ext_dis <= 1'b1;
    // Bus power select toggled above, so its event must be pending
    bus_rd(8'h08, rv); `CHK("int_bus", 1'b1, rv[4])
    // Random power requests and faults, ganged and individual
    for (int t = 0; t < 40; t++) begin
      logic [2:0] f;
      logic       g, tn;
      req = 3'($urandom);
      f   = (t < 4) ? 3'b001 << t[1:0] : 3'($urandom);
      g   = t[0];
      tn  = 1'($urandom);
      @(posedge clk);
      fault    <= 3'b000;
      pin_gang <= g;
      three_n  <= tn;
      slow     <= 1'($urandom);
      ls       <= 3'($urandom);
      bus_wr(8'h00, {29'h0, req});
      wait_n(8);
      `CHK("pwr_clear", exp_pwr(req, 3'b000, g, tn), pen)
      `CHK("slew", ls & present(tn), slew)
      @(posedge clk);
      fault <= f;
      wait_n(2);
      `CHK("pwr_sync", exp_pwr(req, 3'b000, g, tn), pen)
      wait_n(8);
      `CHK("pwr_fault", exp_pwr(req, f, g, tn), pen)
    end
    // Interrupt: masked out, masked in, then cleared by reading
    @(posedge clk);
    fault <= 3'b000;
    bus_wr(8'h00, 32'h0000_0007);
    wait_n(8);
    bus_rd(8'h08, rv);
    bus_wr(8'h0C, 32'h0000_0001);
    wait_n(2);
    `CHK("irq_idle", 1'b0, irq)
    @(posedge clk);
    fault <= 3'b010;
    wait_n(8);
    `CHK("irq_masked", 1'b0, irq)
    @(posedge clk);
    fault <= 3'b011;
    wait_n(8);
    `CHK("irq_set", 1'b1, irq)
    bus_rd(8'h08, rv);
    `CHK("int_stat", 2'b11, rv[1:0])
    wait_n(2);
    `CHK("irq_clear", 1'b0, irq)
    end_of_test();
  end
endmodule : tb_top
